/* File: logic/gcd_pkg.sv */
// Package: offsets, field positions, timing and carrier types of the configuration decoder
package gcd_pkg;

    // ==========================================================
    // Register word indices, byte address divided by four (printed offsets are indices, not all multiples of four)
    localparam logic [8:0] IDX_GAUGE_CFG = 9'h029;
    localparam logic [8:0] IDX_MISC_HIGH = 9'h02a;
    localparam logic [8:0] IDX_MISC_LOW = 9'h02b;
    localparam logic [8:0] IDX_MISC_SECOND = 9'h139;
    localparam logic [8:0] IDX_STATUS = 9'h1f0;
    localparam logic [8:0] IDX_EVENT = 9'h1f1;
    localparam int ADDR_W = 12;

    // ==========================================================
    // Gauge configuration field positions
    localparam int GC_FIXED_LOWEST = 7;
    localparam int GC_CAP_SYNC = 6;
    localparam int GC_CHARGER_TYPE = 5;
    localparam int GC_COMP_EN = 4;
    localparam int GC_THR_SOURCE = 3;
    localparam int GC_OV_SOURCE = 2;
    localparam int GC_CONT_MID = 1;
    localparam int GC_SINGLE_MID = 0;

    // Misc high byte positions (bit 15..8 mapped to 7..0)
    localparam int MH_INT_SENSOR = 7;
    localparam int MH_FE_CHECK = 5;
    localparam int MH_SLEEP_DIS = 4;
    localparam int MH_OT_ACTION = 3;
    localparam int MH_CHG_LED = 2;
    localparam int MH_CELL_DELAY = 0;

    // Misc low byte positions
    localparam int ML_LOW_ALARM_OFF = 7;
    localparam int ML_PRECHG_HI = 6;
    localparam int ML_PRECHG_LO = 5;
    localparam int ML_NONREMOVABLE = 4;
    localparam int ML_CHG_HOLD = 3;
    localparam int ML_DSG_KEEP = 0;

    // Misc second byte, front-end fail config
    localparam int MS_LONG_STRINGS = 5;
    localparam int PF_FE_FAIL = 3;

    // Fixed bits of misc high: b14 reads 0, b9 reads 1
    localparam logic [7:0] MH_FIXED_MASK = 8'h42;
    localparam logic [7:0] MH_FIXED_VAL = 8'h02;
    localparam logic [7:0] ML_FIXED_MASK = 8'h06;
    localparam logic [7:0] MS_FIXED_MASK = 8'hc0;

    // ==========================================================
    // Cell counts and string lengths
    localparam logic [1:0] CELLS_FOUR = 2'h3;
    localparam logic [1:0] CELLS_THREE = 2'h2;
    localparam logic [1:0] CELLS_TWO = 2'h1;
    localparam logic [4:0] MFG_LEN_SHORT = 5'h0b;
    localparam logic [4:0] DEV_LEN_SHORT = 5'h07;
    localparam logic [4:0] LONG_EXTRA = 5'h0f;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int SLEEP_IDLE_MS = 2000;
    localparam int CELL_DELAY_MS = 1000;
    localparam int SLEEP_CYCLES = SLEEP_IDLE_MS * 1000 * CLK_MHZ;
    localparam int CELL_DELAY_CYCLES = CELL_DELAY_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 28;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Carrier types
    typedef enum logic [1:0] {
        PRE_ZERO_VOLT = 2'h0,
        PRE_CHARGE = 2'h1,
        PRE_OVERDISCHARGE = 2'h2,
        PRE_UNDEFINED = 2'h3
    } gcd_prechg_e;

    typedef struct packed {
        logic [7:0] gauge;
        logic [7:0] misc_high;
        logic [7:0] misc_low;
        logic [7:0] misc_second;
    } gcd_cfg_s;

    typedef struct packed {
        logic [2:0] cell_count;
        logic fixed_lowest_threshold;
        logic capacity_sync_on_termination;
        logic charger_type_select;
        logic threshold_compensation_enable;
        logic threshold_source_select;
        logic overvoltage_source_select;
        logic continuous_midrange_correct;
        logic internal_sensor_select;
        logic front_end_check_enable;
        logic overtemp_fet_action;
        logic charge_led_enable;
        logic cell_voltage_flag_delay;
        logic low_alarm_led_off;
        gcd_prechg_e precharge_path_select;
        logic nonremovable_battery;
        logic charge_switch_hold_on;
        logic discharge_switch_keep_on;
        logic long_name_strings;
        logic [4:0] mfg_name_len;
        logic [4:0] dev_name_len;
    } gcd_settings_s;

    typedef struct packed {
        logic [15:0] lowest_end_threshold;
        logic [15:0] middle_end_threshold;
        logic [15:0] upper_end_threshold;
    } gcd_thr_s;

endpackage : gcd_pkg

/* File: logic/gcd_top.sv */
// Configuration byte decoder with AXI4-Lite register access and gauge-core controls
//
// Contract
// - Cell count field 3,2,1 mean four,three,two
// - Fixed lowest threshold; others clamped above it
// - Capacity sync loads percentage on termination
// - Charger type selects learning cycle optimisation
// - Compensation bit picks computed or stored thresholds
// - Threshold source picks pack or lowest cell
// - Overvoltage source: pack or highest cell times count
// - Continuous midrange correction uses voltage points
// - One midrange correction after each reset
// - Sensor select picks internal or external thermistor
// - Front-end check enables comm and fail detect
// - Sleep after 2 s bus low unless disabled
// - Overtemperature action enables FET switch-off
// - Charge LEDs only when charge LED enabled
// - Cell flags delayed one second when enabled
// - Low alarm LEDs blink or go off
// - Precharge field selects precharge switch path
// - Nonremovable clears faults on reverse or low current
// - Nonremovable keeps opposite FET on; removable clears on removal
// - Charge switch hold keeps charge FET after termination
// - Overtemp in charge: charge only or both off
// - Long strings add fifteen characters each
// - Name lengths 11/7 short, 26/22 long
`timescale 1ns/1ps
`default_nettype none

module gcd_top #(
    parameter int SLEEP_CYCLES = gcd_pkg::SLEEP_CYCLES,
    parameter int CELL_DELAY_CYCLES = gcd_pkg::CELL_DELAY_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Nonvolatile storage load
    input wire logic nv_load_i,
    input wire gcd_pkg::gcd_cfg_s nv_cfg_i,
    input wire logic [7:0] pf_config_i,
    // Gauge core inputs
    input wire gcd_pkg::gcd_thr_s thr_stored_i,
    input wire gcd_pkg::gcd_thr_s thr_computed_i,
    input wire logic [15:0] pack_voltage_i,
    input wire logic [15:0] lowest_cell_voltage_i,
    input wire logic [15:0] highest_cell_voltage_i,
    input wire logic termination_i,
    input wire logic discharge_flag_i,
    input wire logic capacity_alarm_i,
    input wire logic blink_i,
    input wire logic overtemp_i,
    input wire logic overtemp_in_charge_i,
    input wire logic cell_ov_raw_i,
    input wire logic cell_uv_raw_i,
    input wire logic fail_is_charge_i,
    input wire logic fail_active_i,
    input wire logic opposite_current_i,
    input wire logic low_current_timeout_i,
    input wire logic battery_removed_i,
    input wire logic smbc_pin_i,
    input wire logic smbd_pin_i,
    // Gauge core outputs
    output gcd_pkg::gcd_settings_s settings_o,
    output gcd_pkg::gcd_thr_s thr_o,
    output logic [15:0] eval_voltage_o,
    output logic [18:0] ov_test_voltage_o,
    output logic rm_sync_load_o,
    output logic midrange_once_o,
    output logic midrange_continuous_o,
    output logic fe_fail_detect_o,
    output logic sleep_req_o,
    output logic led_enable_o,
    output logic cell_overvoltage_flag_o,
    output logic cell_undervoltage_flag_o,
    output logic chg_fet_off_o,
    output logic dsg_fet_off_o,
    output logic fail_clear_o,
    output logic [2:0] precharge_fet_o,
    // AXI4-Lite slave
    input wire logic [gcd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gcd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ==========================================================
    // State
    typedef struct packed {
        gcd_pkg::gcd_cfg_s cfg;
        logic aw_held;
        logic [gcd_pkg::ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic midrange_pending;
        logic cfg_valid;
        logic termination_seen;
        logic [gcd_pkg::CNT_W-1:0] idle_cnt;
        logic sleep;
        logic [gcd_pkg::CNT_W-1:0] ov_cnt;
        logic [gcd_pkg::CNT_W-1:0] uv_cnt;
        logic cell_ov;
        logic cell_uv;
        logic [2:0] smbc_sync;
        logic [2:0] smbd_sync;
        logic bus_low;
    } gcd_state_s;

    gcd_state_s st_q;
    gcd_state_s st_d;
    gcd_pkg::gcd_settings_s set;

    function automatic logic [8:0] word_index(input logic [gcd_pkg::ADDR_W-1:0] a);
        word_index = a[10:2];
    endfunction : word_index

    function automatic logic [15:0] clamp_min(input logic [15:0] v, input logic [15:0] m);
        clamp_min = (v < m) ? m : v;
    endfunction : clamp_min

    function automatic logic [gcd_pkg::CNT_W-1:0] delay_step(
        input logic raw, input logic [gcd_pkg::CNT_W-1:0] c);
        delay_step = !raw ? '0 : (c == gcd_pkg::CNT_W'(CELL_DELAY_CYCLES) ? c : c + 1'b1);
    endfunction : delay_step

    // ==========================================================
    // Decode
    always_comb begin
        set = '0;
        case (st_q.cfg.gauge[1:0])
            gcd_pkg::CELLS_FOUR: set.cell_count = 3'h4;
            gcd_pkg::CELLS_THREE: set.cell_count = 3'h3;
            gcd_pkg::CELLS_TWO: set.cell_count = 3'h2;
            default: set.cell_count = 3'h2;
        endcase
        set.fixed_lowest_threshold = st_q.cfg.gauge[gcd_pkg::GC_FIXED_LOWEST];
        set.capacity_sync_on_termination = st_q.cfg.gauge[gcd_pkg::GC_CAP_SYNC];
        set.charger_type_select = st_q.cfg.gauge[gcd_pkg::GC_CHARGER_TYPE];
        set.threshold_compensation_enable = st_q.cfg.gauge[gcd_pkg::GC_COMP_EN];
        set.threshold_source_select = st_q.cfg.gauge[gcd_pkg::GC_THR_SOURCE];
        set.overvoltage_source_select = st_q.cfg.gauge[gcd_pkg::GC_OV_SOURCE];
        set.continuous_midrange_correct = st_q.cfg.gauge[gcd_pkg::GC_CONT_MID];
        set.internal_sensor_select = st_q.cfg.misc_high[gcd_pkg::MH_INT_SENSOR];
        set.front_end_check_enable = st_q.cfg.misc_high[gcd_pkg::MH_FE_CHECK];
        set.overtemp_fet_action = st_q.cfg.misc_high[gcd_pkg::MH_OT_ACTION];
        set.charge_led_enable = st_q.cfg.misc_high[gcd_pkg::MH_CHG_LED];
        set.cell_voltage_flag_delay = st_q.cfg.misc_high[gcd_pkg::MH_CELL_DELAY];
        set.low_alarm_led_off = st_q.cfg.misc_low[gcd_pkg::ML_LOW_ALARM_OFF];
        set.precharge_path_select = gcd_pkg::gcd_prechg_e'(
            st_q.cfg.misc_low[gcd_pkg::ML_PRECHG_HI:gcd_pkg::ML_PRECHG_LO]);
        set.nonremovable_battery = st_q.cfg.misc_low[gcd_pkg::ML_NONREMOVABLE];
        set.charge_switch_hold_on = st_q.cfg.misc_low[gcd_pkg::ML_CHG_HOLD];
        set.discharge_switch_keep_on = st_q.cfg.misc_low[gcd_pkg::ML_DSG_KEEP];
        set.long_name_strings = st_q.cfg.misc_second[gcd_pkg::MS_LONG_STRINGS];
        set.mfg_name_len = gcd_pkg::MFG_LEN_SHORT + (set.long_name_strings ? gcd_pkg::LONG_EXTRA : 5'h00);
        set.dev_name_len = gcd_pkg::DEV_LEN_SHORT + (set.long_name_strings ? gcd_pkg::LONG_EXTRA : 5'h00);
    end

    assign settings_o = set;

    // ==========================================================
    // Thresholds and voltage selection
    always_comb begin
        if (set.threshold_compensation_enable) begin
            thr_o = thr_computed_i;
        end else begin
            thr_o = thr_stored_i;
        end
        if (set.fixed_lowest_threshold) begin
            thr_o.lowest_end_threshold = thr_stored_i.lowest_end_threshold;
            thr_o.middle_end_threshold = clamp_min(thr_o.middle_end_threshold, thr_stored_i.lowest_end_threshold);
            thr_o.upper_end_threshold = clamp_min(thr_o.upper_end_threshold, thr_stored_i.lowest_end_threshold);
        end
    end

    assign eval_voltage_o = set.threshold_source_select ? pack_voltage_i : lowest_cell_voltage_i;
    assign ov_test_voltage_o = set.overvoltage_source_select ?
        19'(highest_cell_voltage_i) * 19'(set.cell_count) : {3'h0, pack_voltage_i};

    // ==========================================================
    // Gauge-core controls
    assign rm_sync_load_o = termination_i && set.capacity_sync_on_termination;
    assign midrange_once_o = st_q.midrange_pending && st_q.cfg_valid &&
        st_q.cfg.gauge[gcd_pkg::GC_SINGLE_MID];
    assign midrange_continuous_o = set.continuous_midrange_correct;
    assign fe_fail_detect_o = set.front_end_check_enable && pf_config_i[gcd_pkg::PF_FE_FAIL];
    assign sleep_req_o = st_q.sleep;
    assign led_enable_o = (discharge_flag_i || set.charge_led_enable) &&
        !(capacity_alarm_i && (set.low_alarm_led_off || !blink_i));
    assign cell_overvoltage_flag_o = st_q.cell_ov;
    assign cell_undervoltage_flag_o = st_q.cell_uv;
    assign fail_clear_o = battery_removed_i ||
        (set.nonremovable_battery && (opposite_current_i || low_current_timeout_i));

    always_comb begin
        chg_fet_off_o = 1'b0;
        dsg_fet_off_o = 1'b0;
        if (overtemp_i && set.overtemp_fet_action) begin
            chg_fet_off_o = overtemp_in_charge_i;
            dsg_fet_off_o = !overtemp_in_charge_i || !set.discharge_switch_keep_on;
        end
        if (fail_active_i) begin
            chg_fet_off_o = chg_fet_off_o || fail_is_charge_i || !set.nonremovable_battery;
            dsg_fet_off_o = dsg_fet_off_o || !fail_is_charge_i || !set.nonremovable_battery;
        end
        if (st_q.termination_seen && !set.charge_switch_hold_on && !discharge_flag_i) begin
            chg_fet_off_o = 1'b1;
        end
    end

    always_comb begin
        case (set.precharge_path_select)
            gcd_pkg::PRE_ZERO_VOLT: precharge_fet_o = 3'h1;
            gcd_pkg::PRE_CHARGE: precharge_fet_o = 3'h2;
            gcd_pkg::PRE_OVERDISCHARGE: precharge_fet_o = 3'h4;
            default: precharge_fet_o = 3'h0;
        endcase
    end

    // ==========================================================
    // AXI4-Lite slave
    assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
    assign s_axi_wready = !st_q.w_held && !st_q.bvalid;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    always_comb begin
        logic [8:0] idx;
        logic [7:0] wv;
        idx = '0;
        wv = '0;
        st_d = st_q;
        // Address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata[7:0];
            st_d.w_strb = s_axi_wstrb[0];
        end
        if (st_q.aw_held && st_q.w_held) begin
            idx = word_index(st_q.aw_addr);
            wv = st_q.w_data;
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = gcd_pkg::RESP_OKAY;
            case (idx)
                gcd_pkg::IDX_GAUGE_CFG: if (st_q.w_strb) st_d.cfg.gauge = wv;
                gcd_pkg::IDX_MISC_HIGH: if (st_q.w_strb) st_d.cfg.misc_high =
                    (wv & ~gcd_pkg::MH_FIXED_MASK) | gcd_pkg::MH_FIXED_VAL;
                gcd_pkg::IDX_MISC_LOW: if (st_q.w_strb) st_d.cfg.misc_low = wv & ~gcd_pkg::ML_FIXED_MASK;
                gcd_pkg::IDX_MISC_SECOND: if (st_q.w_strb) st_d.cfg.misc_second = wv & ~gcd_pkg::MS_FIXED_MASK;
                gcd_pkg::IDX_STATUS, gcd_pkg::IDX_EVENT: ;
                default: st_d.bresp = gcd_pkg::RESP_SLVERR;
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = gcd_pkg::RESP_OKAY;
            st_d.rdata = '0;
            case (word_index(s_axi_araddr))
                gcd_pkg::IDX_GAUGE_CFG: st_d.rdata[7:0] = st_q.cfg.gauge;
                gcd_pkg::IDX_MISC_HIGH: st_d.rdata[7:0] = st_q.cfg.misc_high;
                gcd_pkg::IDX_MISC_LOW: st_d.rdata[7:0] = st_q.cfg.misc_low;
                gcd_pkg::IDX_MISC_SECOND: st_d.rdata[7:0] = st_q.cfg.misc_second;
                gcd_pkg::IDX_STATUS: st_d.rdata[12:0] = {set.dev_name_len, set.mfg_name_len, set.cell_count};
                gcd_pkg::IDX_EVENT: st_d.rdata[4:0] = {st_q.termination_seen, st_q.midrange_pending,
                    st_q.sleep, st_q.cell_uv, st_q.cell_ov};
                default: st_d.rresp = gcd_pkg::RESP_SLVERR;
            endcase
        end
        // Storage load overrides a register write in the same cycle
        if (nv_load_i) begin
            st_d.cfg = nv_cfg_i;
            st_d.cfg.misc_high = (nv_cfg_i.misc_high & ~gcd_pkg::MH_FIXED_MASK) | gcd_pkg::MH_FIXED_VAL;
            st_d.cfg.misc_low = nv_cfg_i.misc_low & ~gcd_pkg::ML_FIXED_MASK;
            st_d.cfg.misc_second = nv_cfg_i.misc_second & ~gcd_pkg::MS_FIXED_MASK;
            st_d.cfg_valid = 1'b1;
        end

        // ==========================================================
        // Midrange one-shot and termination tracking
        if (st_q.midrange_pending && st_q.cfg_valid) begin
            st_d.midrange_pending = 1'b0;
        end
        if (termination_i) begin
            st_d.termination_seen = 1'b1;
        end else if (discharge_flag_i) begin
            st_d.termination_seen = 1'b0;
        end

        // Bus idle detection, filtered pins
        st_d.smbc_sync = {st_q.smbc_sync[1:0], smbc_pin_i};
        st_d.smbd_sync = {st_q.smbd_sync[1:0], smbd_pin_i};
        if (st_q.smbc_sync[2] == st_q.smbc_sync[1] && st_q.smbd_sync[2] == st_q.smbd_sync[1]) begin
            st_d.bus_low = !st_q.smbc_sync[1] && !st_q.smbd_sync[1];
        end
        if (!st_q.bus_low || st_q.cfg.misc_high[gcd_pkg::MH_SLEEP_DIS]) begin
            st_d.idle_cnt = '0;
            st_d.sleep = 1'b0;
        end else if (st_q.idle_cnt == gcd_pkg::CNT_W'(SLEEP_CYCLES - 1)) begin
            st_d.sleep = 1'b1;
        end else begin
            st_d.idle_cnt = st_q.idle_cnt + 1'b1;
        end

        // Cell flag delay
        st_d.ov_cnt = delay_step(cell_ov_raw_i, st_q.ov_cnt);
        st_d.uv_cnt = delay_step(cell_uv_raw_i, st_q.uv_cnt);
        st_d.cell_ov = cell_ov_raw_i && (!set.cell_voltage_flag_delay ||
            st_q.ov_cnt == gcd_pkg::CNT_W'(CELL_DELAY_CYCLES));
        st_d.cell_uv = cell_uv_raw_i && (!set.cell_voltage_flag_delay ||
            st_q.uv_cnt == gcd_pkg::CNT_W'(CELL_DELAY_CYCLES));
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.cfg.misc_high <= gcd_pkg::MH_FIXED_VAL;
            st_q.midrange_pending <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Checks
    sequence term_seq;
        termination_i && set.capacity_sync_on_termination;
    endsequence

    cap_sync_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        termination_i |-> (rm_sync_load_o == set.capacity_sync_on_termination))
        else $error("capacity sync load wrong");
    thr_fixed_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        set.fixed_lowest_threshold |-> (thr_o.lowest_end_threshold == thr_stored_i.lowest_end_threshold
        && thr_o.middle_end_threshold >= thr_o.lowest_end_threshold))
        else $error("fixed lowest threshold broken");
    comp_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!set.fixed_lowest_threshold && !set.threshold_compensation_enable) |-> thr_o == thr_stored_i)
        else $error("stored thresholds not used");
    eval_src_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !set.threshold_source_select |-> eval_voltage_o == lowest_cell_voltage_i)
        else $error("threshold source wrong");
    sleep_dis_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q.cfg.misc_high[gcd_pkg::MH_SLEEP_DIS] |=> !sleep_req_o)
        else $error("sleep while disabled");
    cell_nodelay_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!set.cell_voltage_flag_delay && cell_ov_raw_i) ##1 !set.cell_voltage_flag_delay |-> cell_overvoltage_flag_o)
        else $error("undelayed flag late");
    ot_none_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!set.overtemp_fet_action && !fail_active_i && !discharge_flag_i && set.charge_switch_hold_on)
        |-> !dsg_fet_off_o)
        else $error("FET action without enable");
    led_chg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!discharge_flag_i && !set.charge_led_enable) |-> !led_enable_o)
        else $error("charge LEDs without enable");
    name_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        set.long_name_strings |-> (set.mfg_name_len == 5'd26 && set.dev_name_len == 5'd22))
        else $error("long name lengths wrong");

endmodule : gcd_top

`default_nettype wire

/* File: tb/gcd_host_model.sv */
// SMBus host model: clock line toggles as traffic, both lines park low on command
`timescale 1ns/1ps
`default_nettype none
module gcd_host_model (
    input wire logic clk_i,
    input wire logic park_i,
    output logic smbc_o,
    output logic smbd_o
);
    initial {smbc_o, smbd_o} = 2'h3;
    always @(posedge clk_i) begin
        smbc_o <= park_i ? 1'b0 : ~smbc_o;
        smbd_o <= ~park_i;
    end
endmodule : gcd_host_model
`default_nettype wire

/* File: tb/gauge_config_decode_test.sv */
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
`default_nettype none
module gauge_config_decode_test;
    // ==========================================================
    // Hookup
    logic c = 1'b0, n = 1'b0, ld = 1'b0, pk = 1'b0, sc, sd, slp, aw = 0, w = 0, b = 0, ar = 0, r = 0;
    logic awr, wr_, bv, arr, rv;
    logic [31:0] s = 32'h8812, lv = '0, cf = '0, wd = '0, rdat, got;
    logic [95:0] t = '0;
    logic [47:0] v = '0;
    logic [11:0] wa = '0, ra = '0;
    logic [1:0] br, rr, resp;
    logic [15:0] ev;
    logic [18:0] ov;
    logic [2:0] pf;
    logic [6:0] o;
    gcd_pkg::gcd_settings_s st;
    gcd_pkg::gcd_thr_s th;
    int errors = 0, cmp_count = 0;
    initial forever #5 c = ~c;
    gcd_host_model host_u (.clk_i(c), .park_i(pk), .smbc_o(sc), .smbd_o(sd));
    gcd_top #(.SLEEP_CYCLES(20), .CELL_DELAY_CYCLES(10)) dut_u (.ref_clk_i(c), .rst_n_i(n),
        .nv_load_i(ld), .nv_cfg_i(cf), .pf_config_i(lv[7:0]), .thr_stored_i(t[95:48]), .thr_computed_i(t[47:0]),
        .pack_voltage_i(v[47:32]), .lowest_cell_voltage_i(v[31:16]), .highest_cell_voltage_i(v[15:0]),
        .termination_i(lv[8]), .discharge_flag_i(lv[9]), .capacity_alarm_i(lv[10]), .blink_i(lv[11]),
        .overtemp_i(lv[12]), .overtemp_in_charge_i(lv[13]), .cell_ov_raw_i(lv[14]), .cell_uv_raw_i(lv[15]),
        .fail_is_charge_i(lv[16]), .fail_active_i(lv[17]), .opposite_current_i(lv[18]),
        .low_current_timeout_i(lv[19]), .battery_removed_i(lv[20]), .smbc_pin_i(sc), .smbd_pin_i(sd),
        .settings_o(st), .thr_o(th), .eval_voltage_o(ev), .ov_test_voltage_o(ov), .rm_sync_load_o(o[0]),
        .midrange_once_o(o[1]), .midrange_continuous_o(o[2]), .fe_fail_detect_o(o[3]), .sleep_req_o(slp),
        .led_enable_o(o[4]), .cell_overvoltage_flag_o(), .cell_undervoltage_flag_o(), .chg_fet_off_o(),
        .dsg_fet_off_o(o[5]), .fail_clear_o(o[6]), .precharge_fet_o(pf), .s_axi_awaddr(wa), .s_axi_awvalid(aw),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(w), .s_axi_wready(wr_),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(b), .s_axi_araddr(ra), .s_axi_arvalid(ar),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(r));
    // ==========================================================
    // Tasks
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge c);
        {wa, wd, aw, w, b} <= {a, d, 3'h7};
        do begin
            @(posedge c);
            if (aw && awr) aw <= 1'b0;
            if (w && wr_) w <= 1'b0;
        end while (bv !== 1'b1);
        resp = br;
        b <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge c);
        {ra, ar, r} <= {a, 2'h3};
        do begin
            @(posedge c);
            if (ar && arr) ar <= 1'b0;
        end while (rv !== 1'b1);
        {got, resp} = {rdat, rr};
        r <= 1'b0;
    endtask : rd
    task automatic close_out();
        $display("errors %0d of %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (30000) @(posedge c);
        errors++;
        close_out();
    end
    // ==========================================================
    // Sequence
    initial begin
        repeat (4) @(posedge c);
        n <= 1'b1;
        rd(12'ha8);
        chk(got, 32'h2);
        rd(12'h0);
        chk(resp, gcd_pkg::RESP_SLVERR);
        wr(12'ha4, 32'h5a);
        rd(12'ha4);
        chk(got, 32'h5a);
        wr(12'ha8, 32'h10);
        pk <= 1'b1;
        repeat (40) @(posedge c);
        chk(slp, 0);
        wr(12'ha8, 32'h0);
        repeat (40) @(posedge c);
        chk(slp, 1);
        pk <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            s = lfsr(lfsr(s));
            @(posedge c);
            {ld, cf, lv, t, v} <= {1'b1, s, ~s, s, lfsr(s), ~s, s ^ 32'h5a5a, s[15:0]};
            @(posedge c);
            ld <= 1'b0;
            #1;
            chk(ev, cf[27] ? v[47:32] : v[31:16]);
            chk(th.lowest_end_threshold, cf[28] && !cf[31] ? t[47:32] : t[95:80]);
            if (!cf[26]) chk(ov, v[47:32]);
            else chk(ov, 19'(v[15:0]) * (cf[25:24] == 2'h0 ? 19'h2 : 19'(cf[25:24]) + 19'h1));
            chk(pf, 3'(4'h1 << cf[14:13]));
            chk(st.mfg_name_len, cf[5] ? 5'h1a : 5'h0b);
            chk({st.capacity_sync_on_termination, st.charger_type_select, st.internal_sensor_select}, {cf[30:29], cf[23]});
            chk(o[0], lv[8] & cf[30]);
            chk(o[1], i == 0 && cf[24]);
            chk(o[2], cf[25]);
            chk(o[3], cf[21] & lv[3]);
            chk(o[4], (lv[9] | cf[18]) & !(lv[10] & (cf[15] | !lv[11])));
            chk(o[5], lv[12] & cf[19] & (!lv[13] | !cf[8]) | lv[17] & (!lv[16] | !cf[12]));
            chk(o[6], lv[20] | cf[12] & (lv[18] | lv[19]));
        end
        rd(12'ha8);
        chk(got, (cf[23:16] & 8'hbd) | 8'h02);
        close_out();
    end
endmodule : gauge_config_decode_test
`default_nettype wire
